// [sau_pkg.sv]
// stack arithmetic unit: shared constants, opcodes and flag layout
package sau_pkg;

  // datapath and stack geometry
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int LEVELS = 8;
  localparam int LVL_W = 3;
  localparam int DIGITS = 8;
  localparam int DIG_W = 4;
  localparam int BYTES = 4;

  // register byte offsets on the AXI4-Lite bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_LOAD = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  // stack levels 1..8 read at 0x20..0x3C
  localparam logic [2:0] STK_WIN = 3'h1;
  localparam int STK_WIN_LSB = 5;
  localparam int WORD_LSB = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // decimal constants
  localparam logic [3:0] DIG_MAX = 4'h9;
  localparam logic [3:0] DAB_LIMIT = 4'h4;
  localparam logic [3:0] DAB_ADD = 4'h3;
  localparam logic [31:0] BCD_MODULUS = 32'h05F5E100;

  // operation codes written to the command register
  localparam int OP_W = 3;
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_BCD_STACK_SUBTRACT = 3'b001,
    OP_BCD_STACK_MULTIPLY = 3'b010,
    OP_BCD_STACK_DIVIDE = 3'b011,
    OP_BINARY_STACK_ADD = 3'b100,
    OP_BINARY_STACK_SUBTRACT = 3'b101,
    OP_BINARY_STACK_MULTIPLY = 3'b110
  } sau_op_t;

  // status flags, msb first
  localparam int FLAGS_W = 7;
  typedef struct packed {
    logic operand_range_flag;
    logic invalid_bcd_flag;
    logic sign_error_flag;
    logic negative_flag;
    logic carry_flag;
    logic borrow_flag;
    logic zero_flag;
  } sau_flags_t;

  // which flags each operation updates
  localparam logic [6:0] MASK_NONE = 7'h00;
  localparam logic [6:0] MASK_BCD_SUB = 7'h3B;
  localparam logic [6:0] MASK_BCD_MUL = 7'h29;
  localparam logic [6:0] MASK_BCD_DIV = 7'h69;
  localparam logic [6:0] MASK_BIN_ADD = 7'h1D;
  localparam logic [6:0] MASK_BIN_SUB = 7'h1B;
  localparam logic [6:0] MASK_BIN_MUL = 7'h09;

  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BCD = 1;
  localparam int IRQ_RANGE = 2;

endpackage

// [sau_top.sv]
// stack arithmetic unit: accumulator, eight-level stack, flags, AXI4-Lite slave
//
// Local design decisions: the register addresses and the AXI4-Lite register port.

// Behaviour
// (RQ1) bcd subtract: accumulator minus level 1, 32 bits, result to accumulator
// (RQ2) add, subtract and multiply pop level 1; lower levels move up
// (RQ3) loading the accumulator pushes its old value onto level 1
// (RQ4) bcd multiply: four-digit level 1 times four-digit accumulator into accumulator
// (RQ5) bcd divide: eight-digit accumulator by four-digit level 1, quotient to accumulator
// (RQ6) bcd divide writes remainder into level 1 instead of popping
// (RQ7) binary add: accumulator plus level 1, 32 bits, into accumulator
// (RQ8) binary subtract: accumulator minus level 1, 32 bits, into accumulator
// (RQ9) binary multiply: two 16-bit operands, 32-bit product into accumulator
// (RQ10) zero flag set when accumulator result is zero, cleared otherwise
// (RQ11) negative flag set whenever the accumulator result is negative
// (RQ12) both subtracts set borrow flag on a borrow
// (RQ13) binary add sets carry flag on carry out
// (RQ14) signed add and subtract set sign error flag on overflow
// (RQ15) bcd operations set invalid bcd flag on any non-decimal digit; bcd multiply checks only the low four digits of each operand
// (RQ16) bcd divide sets operand range flag when divisor cannot be handled
// (RQ17) flags hold until an operation affecting them; others stay unchanged
// (RQ18) eight 32-bit levels; accumulator, stack and flags update in one edge
module sau_top (
  input wire logic clk_sys, // system clock, 50 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [sau_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [sau_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [sau_pkg::BYTES-1:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [sau_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [sau_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic irq // level interrupt, high while unmasked status set
);
  import sau_pkg::*;
  // checks that every nibble is a decimal digit
  function automatic logic bcd_ok(input logic [DATA_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int d = 0; d < DIGITS; d++) begin
      if (v[d*DIG_W +: DIG_W] > DIG_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction
  // packed decimal to binary, most significant digit first
  function automatic logic [DATA_W-1:0] bcd2bin(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int d = DIGITS - 1; d >= 0; d--) begin
      r = (r << 3) + (r << 1) + {{(DATA_W-DIG_W){1'b0}}, v[d*DIG_W +: DIG_W]};
    end
    return r;
  endfunction
  // binary to packed decimal by shift and add three
  function automatic logic [DATA_W-1:0] bin2bcd(input logic [DATA_W-1:0] v);
    logic [2*DATA_W-1:0] sh;
    sh = {{DATA_W{1'b0}}, v};
    for (int i = 0; i < DATA_W; i++) begin
      for (int d = 0; d < DIGITS; d++) begin
        if (sh[DATA_W + d*DIG_W +: DIG_W] > DAB_LIMIT) begin
          sh[DATA_W + d*DIG_W +: DIG_W] = sh[DATA_W + d*DIG_W +: DIG_W] + DAB_ADD;
        end
      end
      sh = sh << 1;
    end
    return sh[2*DATA_W-1:DATA_W];
  endfunction
  // architectural state
  logic [DATA_W-1:0] acc_q, acc_d;
  logic [DATA_W-1:0] stk_q [LEVELS];
  logic [DATA_W-1:0] stk_d [LEVELS];
  sau_flags_t flags_q, flags_d;
  sau_op_t last_op_q;
  logic [IRQ_W-1:0] int_stat_q, int_stat_d;
  logic [IRQ_W-1:0] int_mask_q;
  logic irq_q;
  // bus handshake state
  logic aw_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q;
  // write channel decode
  wire wr_start = !aw_rdy_q && !bvalid_q && s_axi_awvalid && s_axi_wvalid;
  wire wr_fire = aw_rdy_q && s_axi_awvalid && s_axi_wvalid;
  wire [DATA_W-1:0] wr_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [DATA_W-1:0] wr_val = s_axi_wdata & wr_mask;
  wire wr_cmd = s_axi_awaddr == OFS_CMD;
  wire wr_load = s_axi_awaddr == OFS_LOAD;
  wire wr_stat = s_axi_awaddr == OFS_INT_STAT;
  wire wr_imask = s_axi_awaddr == OFS_INT_MASK;
  wire wr_hit = wr_cmd || wr_load || wr_stat || wr_imask;
  wire exec_fire = wr_fire && wr_cmd && s_axi_wstrb[0];
  wire load_fire = wr_fire && wr_load;
  wire [DATA_W-1:0] load_val = wr_val;
  wire sau_op_t cmd_op = sau_op_t'(s_axi_wdata[OP_W-1:0]);
  // read channel decode
  wire rd_start = !ar_rdy_q && !rvalid_q && s_axi_arvalid;
  wire rd_fire = ar_rdy_q && s_axi_arvalid;
  wire rd_stk = s_axi_araddr[ADDR_W-1:STK_WIN_LSB] == STK_WIN;
  wire [LVL_W-1:0] rd_lvl = s_axi_araddr[STK_WIN_LSB-1:WORD_LSB];
  wire rd_low = s_axi_araddr[WORD_LSB-1:0] == 2'h0;
  wire rd_cmd = s_axi_araddr == OFS_CMD;
  wire rd_acc = s_axi_araddr == OFS_ACC || s_axi_araddr == OFS_LOAD;
  wire rd_flags = s_axi_araddr == OFS_FLAGS;
  wire rd_stat = s_axi_araddr == OFS_INT_STAT;
  wire rd_imask = s_axi_araddr == OFS_INT_MASK;
  wire rd_hit = (rd_stk && rd_low) || rd_cmd || rd_acc || rd_flags || rd_stat || rd_imask;
  wire [DATA_W-1:0] rd_word =
    (rd_stk && rd_low) ? stk_q[rd_lvl] :
    rd_cmd ? {{(DATA_W-OP_W){1'b0}}, last_op_q} :
    rd_acc ? acc_q :
    rd_flags ? {{(DATA_W-FLAGS_W){1'b0}}, flags_q} :
    rd_stat ? {{(DATA_W-IRQ_W){1'b0}}, int_stat_q} :
    rd_imask ? {{(DATA_W-IRQ_W){1'b0}}, int_mask_q} : '0;
  // operand views of accumulator and stack level 1
  wire [DATA_W-1:0] top = stk_q[0];
  wire [DATA_W-1:0] acc_lo = {{HALF_W{1'b0}}, acc_q[HALF_W-1:0]};
  wire [DATA_W-1:0] top_lo = {{HALF_W{1'b0}}, top[HALF_W-1:0]};
  wire [DATA_W:0] bin_sum = {1'b0, acc_q} + {1'b0, top};
  wire [DATA_W:0] bin_dif = {1'b0, acc_q} - {1'b0, top};
  wire [DATA_W-1:0] bin_prod = acc_lo * top_lo;
  wire [DATA_W-1:0] dec_a = bcd2bin(acc_q);
  wire [DATA_W-1:0] dec_b = bcd2bin(top);
  wire [DATA_W-1:0] dec_al = bcd2bin(acc_lo);
  wire [DATA_W-1:0] dec_bl = bcd2bin(top_lo);
  wire [DATA_W:0] dec_dif = {1'b0, dec_a} - {1'b0, dec_b};
  wire [DATA_W-1:0] dec_wrap = dec_dif[DATA_W-1:0] + BCD_MODULUS;
  wire [DATA_W-1:0] dec_prod = dec_al * dec_bl;
  wire div_zero = dec_bl == '0;
  wire [DATA_W-1:0] dec_quo = div_zero ? '0 : dec_a / dec_bl;
  wire [DATA_W-1:0] dec_rem = div_zero ? '0 : dec_a % dec_bl;
  wire full_ok = bcd_ok(acc_q) && bcd_ok(top);
  wire half_ok = bcd_ok(acc_lo) && bcd_ok(top_lo);
  // operation result selection
  logic [DATA_W-1:0] res_acc;
  logic [DATA_W-1:0] res_rem;
  logic [FLAGS_W-1:0] res_mask;
  logic res_pop, res_div, res_ok;
  sau_flags_t res_flags;
  always_comb begin
    res_acc = acc_q;
    res_rem = top;
    res_mask = MASK_NONE;
    res_pop = 1'b0;
    res_div = 1'b0;
    res_ok = 1'b1;
    res_flags = '0;
    unique case (cmd_op)
      // (RQ1) bcd subtract path
      OP_BCD_STACK_SUBTRACT: begin
        res_mask = MASK_BCD_SUB;
        res_pop = 1'b1;
        // (RQ15) non-decimal digit check
        res_ok = full_ok;
        res_flags.invalid_bcd_flag = !full_ok;
        // (RQ12) decimal borrow out
        res_flags.borrow_flag = full_ok && dec_dif[DATA_W];
        res_flags.negative_flag = full_ok && dec_dif[DATA_W];
        res_acc = bin2bcd(dec_dif[DATA_W] ? dec_wrap : dec_dif[DATA_W-1:0]);
      end
      // (RQ4) bcd multiply four digits
      OP_BCD_STACK_MULTIPLY: begin
        res_mask = MASK_BCD_MUL;
        res_pop = 1'b1;
        res_ok = half_ok;
        res_flags.invalid_bcd_flag = !half_ok;
        res_acc = bin2bcd(dec_prod);
      end
      // (RQ5) bcd divide quotient
      OP_BCD_STACK_DIVIDE: begin
        res_mask = MASK_BCD_DIV;
        res_div = 1'b1;
        // (RQ16) divisor range check
        res_flags.operand_range_flag = div_zero || (top[DATA_W-1:HALF_W] != '0);
        res_flags.invalid_bcd_flag = !full_ok;
        res_ok = full_ok && !res_flags.operand_range_flag;
        res_acc = bin2bcd(dec_quo);
        res_rem = bin2bcd(dec_rem);
      end
      // (RQ7) binary add path
      OP_BINARY_STACK_ADD: begin
        res_mask = MASK_BIN_ADD;
        res_pop = 1'b1;
        res_acc = bin_sum[DATA_W-1:0];
        // (RQ13) carry out of bit 31
        res_flags.carry_flag = bin_sum[DATA_W];
        // (RQ14) signed add overflow
        res_flags.sign_error_flag = (acc_q[DATA_W-1] == top[DATA_W-1])
                                    && (bin_sum[DATA_W-1] != acc_q[DATA_W-1]);
        // (RQ11) sign bit is negative
        res_flags.negative_flag = bin_sum[DATA_W-1];
      end
      // (RQ8) binary subtract path
      OP_BINARY_STACK_SUBTRACT: begin
        res_mask = MASK_BIN_SUB;
        res_pop = 1'b1;
        res_acc = bin_dif[DATA_W-1:0];
        // (RQ12) binary borrow out
        res_flags.borrow_flag = bin_dif[DATA_W];
        // (RQ14) signed subtract overflow
        res_flags.sign_error_flag = (acc_q[DATA_W-1] != top[DATA_W-1])
                                    && (bin_dif[DATA_W-1] != acc_q[DATA_W-1]);
        res_flags.negative_flag = bin_dif[DATA_W-1];
      end
      // (RQ9) binary 16 by 16 multiply
      OP_BINARY_STACK_MULTIPLY: begin
        res_mask = MASK_BIN_MUL;
        res_pop = 1'b1;
        res_acc = bin_prod;
        res_flags.negative_flag = bin_prod[DATA_W-1];
      end
      default: begin
        res_ok = 1'b0;
      end
    endcase
    // (RQ10) zero flag from final accumulator
    res_flags.zero_flag = (res_ok ? res_acc : acc_q) == '0;
  end
  // committed effects of one command write
  wire exec_ok = exec_fire && res_ok;
  wire do_pop = exec_ok && res_pop;
  wire do_rem = exec_ok && res_div;
  // next accumulator: load, result or hold
  // (RQ3) load replaces accumulator
  assign acc_d = load_fire ? load_val : exec_ok ? res_acc : acc_q;
  // (RQ17) only the operation's own flags change
  assign flags_d = exec_fire ? ((flags_q & ~res_mask) | (res_flags & res_mask)) : flags_q;
  // per-level stack movement: push down, pop up, remainder into level 1
  for (genvar g = 0; g < LEVELS; g++) begin : g_lvl
    logic [DATA_W-1:0] from_above, from_below;
    if (g == 0) begin : g_first
      assign from_above = acc_q;
    end else begin : g_inner_a
      assign from_above = stk_q[g-1];
    end
    if (g == LEVELS - 1) begin : g_last
      assign from_below = '0;
    end else begin : g_inner_b
      assign from_below = stk_q[g+1];
    end
    // (RQ3) push old accumulator, (RQ2) pop shifts up, (RQ6) remainder
    assign stk_d[g] = load_fire ? from_above :
                      do_pop ? from_below :
                      (do_rem && g == 0) ? res_rem : stk_q[g];
  end
  // interrupt sources: set wins over a same-cycle write-one-to-clear
  wire [IRQ_W-1:0] irq_evt = {exec_fire && res_flags.operand_range_flag,
                              exec_fire && res_flags.invalid_bcd_flag,
                              exec_fire};
  wire [IRQ_W-1:0] irq_clr = (wr_fire && wr_stat) ? wr_val[IRQ_W-1:0] : '0;
  assign int_stat_d = (int_stat_q & ~irq_clr) | irq_evt;
  // (RQ18) accumulator, stack and flags commit on one edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
      flags_q <= '0;
      stk_q <= '{default: '0};
    end else begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      stk_q <= stk_d;
    end
  end
  // command echo, interrupt status, mask and output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_op_q <= OP_NOP;
      int_stat_q <= '0;
      int_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (exec_fire) begin
        last_op_q <= cmd_op;
      end
      if (wr_fire && wr_imask) begin
        int_mask_q <= wr_val[IRQ_W-1:0];
      end
      int_stat_q <= int_stat_d;
      irq_q <= |(int_stat_d & ((wr_fire && wr_imask) ? wr_val[IRQ_W-1:0] : int_mask_q));
    end
  end
  // write address/data accept and response
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_rdy_q <= wr_start;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  // read address accept and data return
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else begin
      ar_rdy_q <= rd_start;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= rd_word;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  // outputs straight from flip-flops
  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = aw_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq = irq_q;
  // checks on the committed state
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_run(sau_op_t op);
    exec_ok && cmd_op == op;
  endsequence
  sequence s_load;
    load_fire;
  endsequence
  property p_load_push;
    s_load |=> acc_q == $past(load_val) && stk_q[0] == $past(acc_q)
               && stk_q[1] == $past(stk_q[0]);
  endproperty
  a_load_push: assert property (p_load_push) else $error("load did not push"); // RQ3
  property p_pop;
    exec_ok && cmd_op inside {OP_BINARY_STACK_ADD, OP_BINARY_STACK_MULTIPLY,
                              OP_BINARY_STACK_SUBTRACT, OP_BCD_STACK_MULTIPLY,
                              OP_BCD_STACK_SUBTRACT} |=> stk_q[0] == $past(stk_q[1])
                                                     && stk_q[LEVELS-1] == '0;
  endproperty
  a_pop: assert property (p_pop) else $error("stack did not pop"); // RQ2
  property p_div_keep;
    s_run(OP_BCD_STACK_DIVIDE) |=> stk_q[1] == $past(stk_q[1]) && bcd_ok(stk_q[0]);
  endproperty
  a_div_keep: assert property (p_div_keep) else $error("divide moved the stack"); // RQ6
  property p_add;
    s_run(OP_BINARY_STACK_ADD) |=> acc_q == $past(acc_q) + $past(top)
                                   && flags_q.carry_flag == ($past(bin_sum) > 33'hFFFFFFFF);
  endproperty
  a_add: assert property (p_add) else $error("binary add wrong"); // RQ7
  property p_sub;
    s_run(OP_BINARY_STACK_SUBTRACT) |=> acc_q == $past(acc_q) - $past(top)
                                        && flags_q.borrow_flag == ($past(acc_q) < $past(top));
  endproperty
  a_sub: assert property (p_sub) else $error("binary subtract wrong"); // RQ8
  property p_mul;
    s_run(OP_BINARY_STACK_MULTIPLY) |=> acc_q == $past(acc_lo) * $past(top_lo);
  endproperty
  a_mul: assert property (p_mul) else $error("binary multiply wrong"); // RQ9
  property p_zero;
    exec_fire && res_mask != MASK_NONE |=> flags_q.zero_flag == (acc_q == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag mismatch"); // RQ10
  property p_keep_flags;
    exec_fire |=> (flags_q & ~$past(res_mask)) == ($past(flags_q) & ~$past(res_mask));
  endproperty
  a_keep_flags: assert property (p_keep_flags) else $error("unaffected flag changed"); // RQ17
  property p_bad_bcd;
    exec_fire && cmd_op == OP_BCD_STACK_SUBTRACT && !full_ok
      |=> flags_q.invalid_bcd_flag && $stable(acc_q) && int_stat_q[IRQ_BCD];
  endproperty
  a_bad_bcd: assert property (p_bad_bcd) else $error("invalid digit not flagged"); // RQ15
  property p_range;
    exec_fire && cmd_op == OP_BCD_STACK_DIVIDE && div_zero
      |=> flags_q.operand_range_flag && acc_q == $past(acc_q);
  endproperty
  a_range: assert property (p_range) else $error("range flag missing"); // RQ16
endmodule

// [tb.sv]
// self-checking bench for the stack arithmetic unit over its register bus
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sau_pkg::*;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0;
  logic [BYTES-1:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic irq;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [6:0] exp_fl = 7'h00;

  sau_top uut (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    checks_done++;
    if (got !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, got);
    end
  endtask

  // one write: address and data together, bready held until bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  // one read, data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, RESP_OKAY, d);
    chk(nm, e, d);
  endtask

  task automatic ld(input logic [31:0] v);
    wr(OFS_LOAD, v, RESP_OKAY);
  endtask

  // run one command, then check accumulator, level 1, flags and last opcode
  task automatic op(input sau_op_t c, input logic [6:0] m, input logic [6:0] nf,
                    input logic [31:0] acc, input logic [31:0] l1);
    wr(OFS_CMD, {29'h0, c}, RESP_OKAY);
    exp_fl = (exp_fl & ~m) | (nf & m);
    rc(OFS_ACC, acc, "accumulator");
    rc(8'h20, l1, "stack level 1");
    rc(OFS_FLAGS, {25'h0, exp_fl}, "flags");
    rc(OFS_CMD, {29'h0, c}, "last opcode");
  endtask

  task automatic t_reset();
    logic [7:0] a[6] = '{OFS_CMD, OFS_LOAD, OFS_ACC, OFS_FLAGS, OFS_INT_STAT, OFS_INT_MASK};
    foreach (a[i]) rc(a[i], 32'h0, "reset value");
    for (int i = 0; i < 8; i++) rc(8'(32 + 4 * i), 32'h0, "reset level");
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  // nine loads: each pushes, the oldest drops off level 8
  task automatic t_stack();
    for (int i = 1; i <= 9; i++) ld(32'(i));
    rc(OFS_ACC, 32'h9, "accumulator");
    for (int i = 0; i < 8; i++) rc(8'(32 + 4 * i), 32'(8 - i), "stack level");
  endtask

  task automatic t_bcd_sub();
    ld(32'h50);
    ld(32'h20);
    op(OP_BCD_STACK_SUBTRACT, MASK_BCD_SUB, 7'h0A, 32'h99999970, 32'h9);
  endtask

  task automatic t_bcd_mul();
    ld(32'h1234);
    ld(32'h2);
    op(OP_BCD_STACK_MULTIPLY, MASK_BCD_MUL, 7'h00, 32'h2468, 32'h99999970);
  endtask

  task automatic t_bcd_div();
    ld(32'h7);
    ld(32'h100);
    op(OP_BCD_STACK_DIVIDE, MASK_BCD_DIV, 7'h00, 32'h14, 32'h2);
    rc(8'h24, 32'h2468, "stack level 2");
    ld(32'h0);
    ld(32'h100);
    op(OP_BCD_STACK_DIVIDE, MASK_BCD_DIV, 7'h40, 32'h100, 32'h0);
  endtask

  task automatic t_bin_add();
    ld(32'hFFFFFFFF);
    ld(32'h1);
    op(OP_BINARY_STACK_ADD, MASK_BIN_ADD, 7'h05, 32'h0, 32'h100);
  endtask

  task automatic t_bin_sub();
    ld(32'h1);
    ld(32'h80000000);
    op(OP_BINARY_STACK_SUBTRACT, MASK_BIN_SUB, 7'h10, 32'h7FFFFFFF, 32'h0);
    ld(32'h5);
    ld(32'h3);
    op(OP_BINARY_STACK_SUBTRACT, MASK_BIN_SUB, 7'h0A, 32'hFFFFFFFE, 32'h7FFFFFFF);
  endtask

  task automatic t_bin_mul();
    ld(32'h00010003);
    ld(32'hABCDFFFF);
    op(OP_BINARY_STACK_MULTIPLY, MASK_BIN_MUL, 7'h00, 32'h0002FFFD, 32'hFFFFFFFE);
  endtask

  // non-decimal digit, then the interrupt raised, unmasked and cleared
  task automatic t_bad_bcd_irq();
    logic [31:0] d;
    ld(32'h5);
    ld(32'h1A);
    wr(OFS_CMD, {29'h0, OP_BCD_STACK_SUBTRACT}, RESP_OKAY);
    rc(OFS_ACC, 32'h1A, "accumulator");
    rd(OFS_FLAGS, RESP_OKAY, d);
    chk("invalid digit flag", 32'h1, {31'h0, d[5]});
    rc(OFS_INT_STAT, 32'h7, "interrupt status");
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_INT_MASK, 32'h2, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    rc(OFS_INT_MASK, 32'h2, "interrupt mask");
    wr(OFS_INT_STAT, 32'h2, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    rc(OFS_INT_STAT, 32'h5, "interrupt status");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    wr(8'h18, 32'h1, RESP_SLVERR);
    rd(8'h18, RESP_SLVERR, d);
    chk("unmapped read data", 32'h0, d);
    rd(8'h0A, RESP_SLVERR, d);
  endtask

  // byte strobes on load and command, then an undefined opcode that must leave accumulator, level 1 and flags unchanged
  task automatic t_strobes();
    s_axi_wstrb <= 4'h1;
    ld(32'h12345678);
    rc(OFS_ACC, 32'h78, "strobed load");
    rc(8'h20, 32'h1A, "strobed load level 1");
    s_axi_wstrb <= 4'hE;
    wr(OFS_CMD, {29'h0, OP_BINARY_STACK_ADD}, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rc(OFS_ACC, 32'h78, "unstrobed command");
    rc(8'h20, 32'h1A, "unstrobed command level 1");
    wr(OFS_CMD, 32'h7, RESP_OKAY);
    rc(OFS_ACC, 32'h78, "undefined opcode accumulator");
    rc(8'h20, 32'h1A, "undefined opcode level 1");
    rc(OFS_FLAGS, 32'h64, "undefined opcode flags");
  endtask

  // reset for three cycles, then the scenarios in order
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_stack();
    t_bcd_sub();
    t_bcd_mul();
    t_bcd_div();
    t_bin_add();
    t_bin_sub();
    t_bin_mul();
    t_bad_bcd_irq();
    t_unmapped();
    t_strobes();
    summarize();
  end
endmodule
